// file: logic/cmd_integrity_regs.svh
// Constants for the host command integrity and error reporting link
`ifndef CMD_INTEGRITY_REGS_SVH
`define CMD_INTEGRITY_REGS_SVH
`define CMD_WRITE_SETTINGS    8'h03
`define CMD_READ_REG          8'h01
`define CMD_WRITE_REG         8'h02
`define ERR_NONE              8'h00
`define ERR_HARD_FAULT        8'h01
`define ERR_SERIAL_OVERFLOW   8'h02
`define ERR_BAD_CHECKSUM      8'h03
`define ERR_BAD_COMMAND       8'h04
`define ERR_FEW_PARAMS        8'h05
`define ERR_MANY_PARAMS       8'h06
`define ERR_BAD_PARAM         8'h07
`define ERR_BAD_REGISTER      8'h08
`define ERR_UNAUTHORIZED      8'h09
`define ERR_WATCHDOG          8'h0A
`define ERR_OUTPUT_OVERFLOW   8'h0B
`define ERR_BAUD_LOW          8'h0C
`define ERR_ERRBUF_OVERFLOW   8'hFF
`define CHAR_DOLLAR           8'h24
`define CHAR_STAR             8'h2A
`define CHAR_X                8'h58
`define IN_BUF_DEPTH          256
`define OUT_BUF_DEPTH         2048
`define CLK_PERIOD_NS         10
`define TURNAROUND_US         100
`define TURNAROUND_CYCLES     ((`TURNAROUND_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESTART_MS            50
`define RESTART_CYCLES        ((`RESTART_MS * 1000000) / `CLK_PERIOD_NS)
`endif

// file: logic/cmd_integrity_pkg.sv
// Types and functions for the command integrity link; dev_state_t and hex_val serve the device end only
package cmd_integrity_pkg;
  typedef enum logic [1:0] {
    CHECK_NONE = 2'b00,
    CHECK_XOR8 = 2'b01,
    CHECK_CRC16 = 2'b10
  } check_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_BODY  = 3'b001,
    ST_SUM   = 3'b010,
    ST_EXEC  = 3'b011,
    ST_REPLY = 3'b100,
    ST_DEAD  = 3'b101
  } dev_state_t;

  // One CRC step: swap, xor data, fold low nibble, shift 12, shift 5
  function automatic logic [15:0] crc_step(input logic [15:0] crc_in, input logic [7:0] data);
    logic [15:0] c;
    c = {crc_in[7:0], crc_in[15:8]};
    c = c ^ {8'h00, data};
    c = c ^ {12'h000, c[7:4]};
    c = c ^ {c[3:0], 12'h000};
    c = c ^ {3'b000, c[7:0], 5'b00000};
    return c;
  endfunction

  // Hex digit character to nibble
  function automatic logic [3:0] hex_val(input logic [7:0] ch);
    logic [3:0] v;
    v = 4'h0;
    if (ch >= 8'h30 && ch <= 8'h39) v = 4'(ch - 8'h30);
    else if (ch >= 8'h41 && ch <= 8'h46) v = 4'(ch - 8'h37);
    else if (ch >= 8'h61 && ch <= 8'h66) v = 4'(ch - 8'h57);
    return v;
  endfunction
endpackage

// file: logic/cmd_link_if.sv
// Byte stream link between host and device ends
`timescale 1ns/1ps
interface cmd_link_if;
  logic       req_valid;  // Host byte strobe
  logic [7:0] req_byte;   // Host byte
  logic       req_end;    // Last byte of request packet
  logic       rsp_valid;  // Device byte strobe
  logic [7:0] rsp_byte;   // Device byte
  logic       rsp_end;    // Last byte of response

  modport host (output req_valid, req_byte, req_end, input rsp_valid, rsp_byte, rsp_end);
  modport dev  (input req_valid, req_byte, req_end, output rsp_valid, rsp_byte, rsp_end);
endinterface

// file: logic/cmd_device.sv
// Device end: framing, integrity check, error classification and reply
`timescale 1ns/1ps
`include "cmd_integrity_regs.svh"

// Functional notes
// - Write settings answered 00 03 00 00
// - Host waits 100 us before response; here the host counts down but takes the reply as soon as it arrives
// - Reply header: zero, command, argument, error
// - Error reply carries no payload
// - Write to read-only register gives 8
// - Errors emit tag plus code
// - Hard fault reports 1, forces restart
// - Restart done within 50 ms
// - 256-char input overflow gives 2
// - Checksum or CRC mismatch gives 3
// - Unknown command gives 4
// - Parameter faults give 5, 6, 7
// - Unauthorized write gives 9
// - Watchdog reset reports 10 in 50ms
// - 2048-char output overflow gives 11
// - Baud too low gives 12
// - Error buffer overflow gives 255
// - Check mode: xor8, crc16 or none
// - All X digits bypass check
// - XOR of bytes between dollar and star
// - CRC16 CCITT as four hex characters
// - CRC step: swap, xor, shifts 4/12/5
module cmd_device
  import cmd_integrity_pkg::*;
#(
  parameter int RESTART_CYCLES = `RESTART_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  cmd_link_if.dev          link,
  input  wire check_mode_t check_mode,
  input  wire logic [7:0]  cmd_known_mask,
  input  wire logic [7:0]  cmd_min_params,
  input  wire logic [7:0]  cmd_max_params,
  input  wire logic        param_invalid,
  input  wire logic        reg_read_only,
  input  wire logic        reg_locked,
  input  wire logic        reg_exists,
  input  wire logic        hard_fault,
  input  wire logic        fatal_error,
  input  wire logic        out_push,
  input  wire logic        out_pop,
  input  wire logic        baud_short,
  input  wire logic        err_buf_full,
  output logic             err_valid,
  output logic [7:0]       err_code,
  output logic             restarting
);

  typedef struct packed {
    dev_state_t  state;
    logic [7:0]  cmd;
    logic [7:0]  arg;
    logic [7:0]  code;
    logic [1:0]  pos;
    logic [8:0]  in_count;
    logic [11:0] out_count;
    logic [7:0]  params;
    logic [7:0]  xor_acc;
    logic [15:0] crc_acc;
    logic [15:0] rx_sum;
    logic [2:0]  sum_digits;
    logic        all_x;
    logic        in_ovf;
    logic        rsp_valid;
    logic [7:0]  rsp_byte;
    logic        rsp_end;
    logic        err_valid;
    logic [7:0]  err_code;
    logic [31:0] restart_cnt;
    logic        restarting;
  } dev_regs_t;

  dev_regs_t r;
  dev_regs_t next_r;

  //----------------------------------------------------------
  // Next state
  //----------------------------------------------------------
  always_comb begin
    logic [7:0] b;
    logic [2:0] need;
    logic       mismatch;
    next_r = r;
    b = link.req_byte;
    need = (check_mode == CHECK_CRC16) ? 3'd4 : 3'd2;
    mismatch = 1'b0;
    next_r.rsp_valid = 1'b0;
    next_r.rsp_end = 1'b0;
    next_r.err_valid = 1'b0;
    // Output buffer occupancy; overflow reported
    if (out_push && !out_pop) begin
      if (r.out_count == 12'(`OUT_BUF_DEPTH)) begin
        next_r.err_valid = 1'b1;
        next_r.err_code = `ERR_OUTPUT_OVERFLOW;
      end else begin
        next_r.out_count = r.out_count + 12'h001;
      end
    end else if (out_pop && !out_push && r.out_count != 12'h000) begin
      next_r.out_count = r.out_count - 12'h001;
    end
    // Background faults
    if (baud_short) begin
      next_r.err_valid = 1'b1;
      next_r.err_code = `ERR_BAUD_LOW;
    end
    if (err_buf_full) begin
      next_r.err_valid = 1'b1;
      next_r.err_code = `ERR_ERRBUF_OVERFLOW;
    end
    case (r.state)
      ST_IDLE, ST_BODY: begin
        if (link.req_valid) begin
          if (b == `CHAR_DOLLAR) begin
            next_r.state = ST_BODY;
            next_r.xor_acc = 8'h00;
            next_r.crc_acc = 16'h0000;
            next_r.pos = 2'd0;
            next_r.in_count = 9'h000;
            next_r.in_ovf = 1'b0;
            next_r.params = 8'h00;
          end else if (r.state == ST_BODY) begin
            if (r.in_count == 9'(`IN_BUF_DEPTH)) next_r.in_ovf = 1'b1;
            else next_r.in_count = r.in_count + 9'h001;
            if (b == `CHAR_STAR) begin
              next_r.state = ST_SUM;
              next_r.sum_digits = 3'd0;
              next_r.all_x = 1'b1;
              next_r.rx_sum = 16'h0000;
            end else begin
              next_r.xor_acc = r.xor_acc ^ b;
              next_r.crc_acc = crc_step(r.crc_acc, b);
              if (b == 8'h2C) next_r.params = r.params + 8'h01;
              if (r.pos == 2'd0) next_r.cmd = b;
              if (r.pos == 2'd1) next_r.arg = b;
              if (r.pos != 2'd3) next_r.pos = r.pos + 2'd1;
            end
          end
        end
      end
      ST_SUM: begin
        if (check_mode == CHECK_NONE) begin
          next_r.state = ST_EXEC;
        end else if (link.req_valid) begin
          next_r.rx_sum = {r.rx_sum[11:0], hex_val(b)};
          next_r.all_x = r.all_x && (b == `CHAR_X);
          next_r.sum_digits = r.sum_digits + 3'd1;
          if (r.sum_digits + 3'd1 == need) next_r.state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (check_mode == CHECK_XOR8) mismatch = r.rx_sum[7:0] != r.xor_acc;
        else if (check_mode == CHECK_CRC16) mismatch = r.rx_sum != r.crc_acc;
        if (r.all_x) mismatch = 1'b0;
        next_r.code = `ERR_NONE;
        if (r.in_ovf) next_r.code = `ERR_SERIAL_OVERFLOW;
        else if (check_mode != CHECK_NONE && mismatch) next_r.code = `ERR_BAD_CHECKSUM;
        else if (!cmd_known_mask[r.cmd[2:0]] || r.cmd[7:3] != 5'h00) next_r.code = `ERR_BAD_COMMAND;
        else if (r.params < cmd_min_params) next_r.code = `ERR_FEW_PARAMS;
        else if (r.params > cmd_max_params) next_r.code = `ERR_MANY_PARAMS;
        else if (param_invalid) next_r.code = `ERR_BAD_PARAM;
        else if (r.cmd == `CMD_WRITE_REG && (reg_read_only || !reg_exists)) next_r.code = `ERR_BAD_REGISTER;
        else if (r.cmd == `CMD_WRITE_REG && reg_locked) next_r.code = `ERR_UNAUTHORIZED;
        next_r.pos = 2'd0;
        next_r.state = ST_REPLY;
      end
      ST_REPLY: begin
        // Header only: zero, command, argument, error byte
        next_r.rsp_valid = 1'b1;
        case (r.pos)
          2'd0: next_r.rsp_byte = 8'h00;
          2'd1: next_r.rsp_byte = r.cmd;
          2'd2: next_r.rsp_byte = r.arg;
          default: next_r.rsp_byte = r.code;
        endcase
        next_r.pos = r.pos + 2'd1;
        if (r.pos == 2'd3) begin
          next_r.rsp_end = 1'b1;
          next_r.state = ST_IDLE;
          if (r.code != `ERR_NONE) begin
            next_r.err_valid = 1'b1;
            next_r.err_code = r.code;
          end
        end
      end
      ST_DEAD: begin
        // Forced restart countdown
        if (r.restart_cnt == 32'h0) begin
          next_r.restarting = 1'b0;
          next_r.state = ST_IDLE;
        end else begin
          next_r.restart_cnt = r.restart_cnt - 32'h1;
        end
      end
      default: next_r.state = ST_IDLE;
    endcase
    if (r.state != ST_DEAD && (hard_fault || fatal_error)) begin
      next_r.state = ST_DEAD;
      next_r.restarting = 1'b1;
      next_r.restart_cnt = 32'(RESTART_CYCLES - 1);
      next_r.err_valid = 1'b1;
      next_r.err_code = hard_fault ? `ERR_HARD_FAULT : `ERR_WATCHDOG;
    end
  end

  //----------------------------------------------------------
  // State register
  //----------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign link.rsp_valid = r.rsp_valid;
  assign link.rsp_byte  = r.rsp_byte;
  assign link.rsp_end   = r.rsp_end;
  assign err_valid      = r.err_valid;
  assign err_code       = r.err_code;
  assign restarting     = r.restarting;

endmodule // cmd_device

// file: logic/cmd_host.sv
// Host end: frames a command with check field, waits, collects reply
`timescale 1ns/1ps
`include "cmd_integrity_regs.svh"

module cmd_host
  import cmd_integrity_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  cmd_link_if.host         link,
  input  wire check_mode_t check_mode,
  input  wire logic        bypass,
  input  wire logic        send,
  input  wire logic [7:0]  send_cmd,
  input  wire logic [7:0]  send_arg,
  output logic             busy,
  output logic             done,
  output logic [7:0]       reply_code,
  output logic [7:0]       reply_cmd
);

  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_BODY = 3'b001, H_SUM = 3'b010, H_WAIT = 3'b011, H_RX = 3'b100
  } host_state_t;

  typedef struct packed {
    host_state_t state;
    logic [2:0]  idx;
    logic [7:0]  cmd;
    logic [7:0]  arg;
    logic [7:0]  xor_acc;
    logic [15:0] crc_acc;
    logic [15:0] wait_cnt;
    logic [1:0]  rx_pos;
    logic        req_valid;
    logic [7:0]  req_byte;
    logic        req_end;
    logic        busy;
    logic        done;
    logic [7:0]  reply_code;
    logic [7:0]  reply_cmd;
  } host_regs_t;

  host_regs_t r;
  host_regs_t next_r;

  // Nibble to upper-case hex character
  function automatic logic [7:0] hex_chr(input logic [3:0] n);
    return (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction

  //----------------------------------------------------------
  // Next state
  //----------------------------------------------------------
  always_comb begin
    logic [7:0]  b;
    logic [15:0] s;
    logic [2:0]  need;
    next_r = r;
    b = 8'h00;
    need = (check_mode == CHECK_CRC16) ? 3'd4 : 3'd2;
    s = (check_mode == CHECK_CRC16) ? r.crc_acc : {r.xor_acc, 8'h00};
    next_r.req_valid = 1'b0;
    next_r.req_end = 1'b0;
    next_r.done = 1'b0;
    case (r.state)
      H_IDLE: begin
        if (send) begin
          next_r.cmd = send_cmd;
          next_r.arg = send_arg;
          next_r.busy = 1'b1;
          next_r.req_valid = 1'b1;
          next_r.req_byte = `CHAR_DOLLAR;
          next_r.xor_acc = 8'h00;
          next_r.crc_acc = 16'h0000;
          next_r.idx = 3'd0;
          next_r.state = H_BODY;
        end
      end
      H_BODY: begin
        b = (r.idx == 3'd0) ? r.cmd : (r.idx == 3'd1) ? r.arg : `CHAR_STAR;
        next_r.req_valid = 1'b1;
        next_r.req_byte = b;
        next_r.idx = r.idx + 3'd1;
        if (r.idx == 3'd2) begin
          next_r.idx = 3'd0;
          next_r.state = (check_mode == CHECK_NONE) ? H_WAIT : H_SUM;
          next_r.req_end = (check_mode == CHECK_NONE);
          next_r.wait_cnt = 16'(`TURNAROUND_CYCLES);
        end else begin
          next_r.xor_acc = r.xor_acc ^ b;
          next_r.crc_acc = crc_step(r.crc_acc, b);
        end
      end
      H_SUM: begin
        next_r.req_valid = 1'b1;
        next_r.req_byte = bypass ? `CHAR_X : hex_chr(s[15 - 4 * r.idx -: 4]);
        next_r.idx = r.idx + 3'd1;
        if (r.idx + 3'd1 == need) begin
          next_r.req_end = 1'b1;
          next_r.state = H_WAIT;
        end
      end
      H_WAIT: begin
        // Turnaround count runs down; response clocked in without waiting for it
        if (r.wait_cnt != 16'h0000) next_r.wait_cnt = r.wait_cnt - 16'h0001;
        next_r.rx_pos = 2'd0;
        if (link.rsp_valid) begin
          next_r.rx_pos = 2'd1;
          next_r.state = H_RX;
        end
      end
      H_RX: begin
        if (link.rsp_valid) begin
          if (r.rx_pos == 2'd1) next_r.reply_cmd = link.rsp_byte;
          if (r.rx_pos == 2'd3) next_r.reply_code = link.rsp_byte;
          next_r.rx_pos = r.rx_pos + 2'd1;
          if (link.rsp_end) begin
            next_r.busy = 1'b0;
            next_r.done = 1'b1;
            next_r.state = H_IDLE;
          end
        end
      end
      default: next_r.state = H_IDLE;
    endcase
  end

  //----------------------------------------------------------
  // State register
  //----------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign link.req_valid = r.req_valid;
  assign link.req_byte  = r.req_byte;
  assign link.req_end   = r.req_end;
  assign busy           = r.busy;
  assign done           = r.done;
  assign reply_code     = r.reply_code;
  assign reply_cmd      = r.reply_cmd;

endmodule // cmd_host

// file: verif/cmd_link_properties.sv
// Concurrent checks on the link that joins the host end to the device end
`timescale 1ns/1ps
module cmd_link_properties (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       req_valid,
  input wire logic [7:0] req_byte,
  input wire logic       req_end,
  input wire logic       rsp_valid,
  input wire logic [7:0] rsp_byte,
  input wire logic       rsp_end
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [1:0] pos;
  logic [7:0] cmd;
  logic [7:0] arg;
  // ----------------------------------------
  // Frame tracking
  // ----------------------------------------
  // Position in the request frame; captures command and argument
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pos <= 2'h0;
    end else if (req_valid) begin
      if (req_end) begin
        pos <= 2'h0;
      end else if (pos == 2'h0) begin
        pos <= (req_byte == 8'h24) ? 2'h1 : 2'h0;
      end else if (pos != 2'h3) begin
        pos <= pos + 2'h1;
      end
      if (pos == 2'h1) begin
        cmd <= req_byte;
      end
      if (pos == 2'h2) begin
        arg <= req_byte;
      end
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  AST_HDR_FOURTH: assert property (rsp_end |-> rsp_valid && $past(rsp_valid, 3))
    else $error("end marker not on fourth header byte");
  AST_LEAD_ZERO: assert property ($rose(rsp_valid) |-> rsp_byte == 8'h00)
    else $error("reply header does not start with zero");
  AST_FOUR_ONLY: assert property ($rose(rsp_valid) |-> rsp_valid [*4] ##1 !rsp_valid)
    else $error("reply is not exactly four bytes");
  AST_ECHO: assert property ($rose(rsp_valid) |=> rsp_byte == cmd ##1 rsp_byte == arg)
    else $error("reply does not echo command and argument");
  AST_REPLY_GAP: assert property (req_end && req_byte != 8'h2A |=> !rsp_valid ##1 !rsp_valid ##1 $rose(rsp_valid))
    else $error("reply not three cycles after last check digit");
  AST_REPLY_GAP_NONE: assert property (req_end && req_byte == 8'h2A |=> !rsp_valid [*3] ##1 $rose(rsp_valid))
    else $error("reply not four cycles after unchecked request end");
  AST_WS_OK: assert property ($rose(rsp_valid) && cmd == 8'h03 |-> ##3 rsp_end && rsp_byte == 8'h00)
    else $error("write settings reply carries an error");
  AST_START_MARK: assert property (req_valid && pos == 2'h0 |-> req_byte == 8'h24)
    else $error("request frame does not open with start marker");
  AST_HOST_QUIET: assert property (req_end |=> !req_valid [*6])
    else $error("host sends before reply is over");
  // Main scenarios seen
  cover property ($rose(rsp_valid) && cmd == 8'h03);
  cover property (rsp_end && rsp_byte != 8'h00);
  cover property (req_valid && req_byte == 8'h58);
endmodule // cmd_link_properties

// file: verif/host_cmd_integrity_errors_bench.sv
// Bench: host and device ends face to face, plus a raw driver on a second link
`timescale 1ns/1ps
`include "cmd_integrity_regs.svh"
module host_cmd_integrity_errors_bench import cmd_integrity_pkg::*; ;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  check_mode_t check_mode = CHECK_NONE;
  logic        bypass = 1'b0;
  logic        send = 1'b0;
  logic [7:0]  send_cmd = 8'h00;
  logic [7:0]  send_arg = 8'h00;
  logic        busy, done, ev1, ev2, rs1, rs2;
  logic [7:0]  reply_code, reply_cmd, ec1, ec2, err2;
  logic [7:0]  cmd_known_mask = 8'h0F;
  logic [7:0]  cmd_min_params = 8'h00;
  logic [7:0]  cmd_max_params = 8'h00;
  logic        param_invalid = 1'b0, reg_read_only = 1'b0, reg_locked = 1'b0, reg_exists = 1'b1;
  logic        hard_fault = 1'b0, fatal_error = 1'b0, out_push = 1'b0, out_pop = 1'b0;
  logic        baud_short = 1'b0, err_buf_full = 1'b0;
  logic [7:0]  q[$];
  int          cnt2 = 0, miscompares = 0, total_checks = 0, k;

  cmd_link_if cmd_link_if_inst ();
  cmd_link_if cmd_link_if_inst2 ();
  cmd_host cmd_host_inst (.core_clk(core_clk), .rst(rst), .link(cmd_link_if_inst), .check_mode(check_mode),
    .bypass(bypass), .send(send), .send_cmd(send_cmd), .send_arg(send_arg), .busy(busy), .done(done),
    .reply_code(reply_code), .reply_cmd(reply_cmd));
  cmd_device #(.RESTART_CYCLES(50)) cmd_device_inst (.core_clk(core_clk), .rst(rst), .link(cmd_link_if_inst),
    .check_mode(check_mode), .cmd_known_mask(cmd_known_mask), .cmd_min_params(cmd_min_params),
    .cmd_max_params(cmd_max_params), .param_invalid(param_invalid), .reg_read_only(reg_read_only),
    .reg_locked(reg_locked), .reg_exists(reg_exists), .hard_fault(hard_fault), .fatal_error(fatal_error),
    .out_push(out_push), .out_pop(out_pop), .baud_short(baud_short), .err_buf_full(err_buf_full),
    .err_valid(ev1), .err_code(ec1), .restarting(rs1));
  cmd_device #(.RESTART_CYCLES(50)) cmd_device_inst2 (.core_clk(core_clk), .rst(rst), .link(cmd_link_if_inst2),
    .check_mode(check_mode), .cmd_known_mask(cmd_known_mask), .cmd_min_params(cmd_min_params),
    .cmd_max_params(cmd_max_params), .param_invalid(param_invalid), .reg_read_only(reg_read_only),
    .reg_locked(reg_locked), .reg_exists(reg_exists), .hard_fault(hard_fault), .fatal_error(fatal_error),
    .out_push(out_push), .out_pop(out_pop), .baud_short(baud_short), .err_buf_full(err_buf_full),
    .err_valid(ev2), .err_code(ec2), .restarting(rs2));
  cmd_link_properties cmd_link_properties_inst (.core_clk(core_clk), .rst(rst),
    .req_valid(cmd_link_if_inst.req_valid), .req_byte(cmd_link_if_inst.req_byte),
    .req_end(cmd_link_if_inst.req_end), .rsp_valid(cmd_link_if_inst.rsp_valid),
    .rsp_byte(cmd_link_if_inst.rsp_byte), .rsp_end(cmd_link_if_inst.rsp_end));

  // Clock
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  // Wire monitor on the main link, reply monitor on the second
  always @(posedge core_clk) begin
    if (cmd_link_if_inst.req_valid === 1'b1) q.push_back(cmd_link_if_inst.req_byte);
    if (cmd_link_if_inst2.rsp_end === 1'b1) begin
      err2 <= cmd_link_if_inst2.rsp_byte;
      cnt2 <= cnt2 + 1;
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic logic [7:0] hx(input logic [3:0] v);
    return (v < 4'hA) ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One host transaction; checks reply and the check field on the wire
  task automatic host_txn(input logic [7:0] c, input logic [7:0] a, input logic [7:0] e);
    int n, d, i;
    logic [7:0] x;
    logic [15:0] r;
    logic [3:0] nib;
    q = {};
    send <= 1'b1;
    send_cmd <= c;
    send_arg <= a;
    @(posedge core_clk);
    send <= 1'b0;
    @(posedge core_clk);
    chk(8'(busy), 8'h01, "busy while waiting");
    n = 1;
    do begin
      @(posedge core_clk);
      n++;
    end while (done !== 1'b1 && n < 400);
    if (done !== 1'b1) begin
      miscompares++;
      $display("mismatch at %0t: no reply from device", $time);
    end
    chk(8'(busy), 8'h00, "busy after reply");
    chk(reply_code, e, "reply code");
    chk(reply_cmd, c, "reply command");
    @(posedge core_clk);
    if (e != `ERR_NONE) chk(ec1, e, "error code");
    d = (check_mode == CHECK_XOR8) ? 2 : (check_mode == CHECK_CRC16) ? 4 : 0;
    n = q.size();
    x = 8'h00;
    r = 16'h0000;
    for (i = 1; i < n - d - 1; i++) begin
      x = x ^ q[i];
      r = {r[7:0], r[15:8]} ^ {8'h00, q[i]};
      r = r ^ {12'h000, r[7:4]};
      r = r ^ {r[3:0], 12'h000};
      r = r ^ {3'h0, r[7:0], 5'h00};
    end
    chk(q[n - d - 1], 8'h2A, "end marker");
    for (i = 0; i < d; i++) begin
      nib = (d == 2) ? 4'(x >> (4 * (1 - i))) : 4'(r >> (4 * (3 - i)));
      chk(q[n - d + i], bypass ? 8'h58 : hx(nib), "digit");
    end
  endtask
  // Raw xor8 frame on the second link; bad flips the low bit of the check value
  task automatic raw(input logic [7:0] c, input int np, input logic bad, input logic [7:0] e);
    logic [7:0] f[$];
    logic [7:0] x;
    int n, c0;
    f = {8'h24, c, 8'h00};
    repeat (np) f.push_back(8'h2C);
    x = {7'h00, bad};
    for (n = 1; n < f.size(); n++) x = x ^ f[n];
    f.push_back(8'h2A);
    f.push_back(hx(x[7:4]));
    f.push_back(hx(x[3:0]));
    c0 = cnt2;
    foreach (f[i]) begin
      cmd_link_if_inst2.req_valid <= 1'b1;
      cmd_link_if_inst2.req_byte <= f[i];
      cmd_link_if_inst2.req_end <= (i == f.size() - 1);
      @(posedge core_clk);
    end
    cmd_link_if_inst2.req_valid <= 1'b0;
    cmd_link_if_inst2.req_byte <= ~x;
    cmd_link_if_inst2.req_end <= 1'b0;
    n = 0;
    while (cnt2 == c0 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    if (cnt2 == c0) begin
      miscompares++;
      $display("mismatch at %0t: no raw reply from device", $time);
    end
    chk(err2, e, "raw reply error");
  endtask
  // Pulse one event input of the devices, then check the held code
  task automatic evt(input logic [3:0] s, input logic [7:0] e);
    {hard_fault, fatal_error, baud_short, err_buf_full} <= s;
    @(posedge core_clk);
    {hard_fault, fatal_error, baud_short, err_buf_full} <= 4'h0;
    @(posedge core_clk);
    chk(8'(ev2), 8'(s != 4'h0), "event strobe");
    repeat (2) @(posedge core_clk);
    chk(ec2, e, "event code");
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    cmd_link_if_inst2.req_valid <= 1'b0;
    cmd_link_if_inst2.req_byte <= 8'h00;
    cmd_link_if_inst2.req_end <= 1'b0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    // Every check mode, with and without bypass
    for (k = 0; k < 6; k++) begin
      check_mode <= check_mode_t'(2'(k % 3));
      bypass <= (k > 2);
      host_txn(8'h03, 8'h00, `ERR_NONE);
    end
    bypass <= 1'b0;
    host_txn(8'h05, 8'h00, `ERR_BAD_COMMAND);
    reg_read_only <= 1'b1;
    host_txn(8'h02, 8'h12, `ERR_BAD_REGISTER);
    reg_read_only <= 1'b0;
    reg_locked <= 1'b1;
    host_txn(8'h02, 8'h12, `ERR_UNAUTHORIZED);
    reg_locked <= 1'b0;
    cmd_min_params <= 8'h01;
    host_txn(8'h02, 8'h12, `ERR_FEW_PARAMS);
    cmd_min_params <= 8'h00;
    param_invalid <= 1'b1;
    host_txn(8'h02, 8'h12, `ERR_BAD_PARAM);
    param_invalid <= 1'b0;
    // Device faults and restart
    evt(4'h8, `ERR_HARD_FAULT);
    chk(8'(rs2), 8'h01, "restart begun");
    chk(8'(rs1), 8'h01, "restart begun on main link");
    repeat (55) @(posedge core_clk);
    chk(8'(rs2), 8'h00, "restart over");
    evt(4'h4, `ERR_WATCHDOG);
    repeat (60) @(posedge core_clk);
    evt(4'h2, `ERR_BAUD_LOW);
    evt(4'h1, `ERR_ERRBUF_OVERFLOW);
    out_push <= 1'b1;
    repeat (2048) @(posedge core_clk);
    out_push <= 1'b0;
    out_pop <= 1'b1;
    @(posedge core_clk);
    out_pop <= 1'b0;
    out_push <= 1'b1;
    @(posedge core_clk);
    out_push <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(ec2, `ERR_ERRBUF_OVERFLOW, "output not yet overflowed");
    evt(4'h0, `ERR_ERRBUF_OVERFLOW);
    out_push <= 1'b1;
    @(posedge core_clk);
    out_push <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(ec2, `ERR_OUTPUT_OVERFLOW, "output overflow");
    // Raw frames from a misbehaving host
    check_mode <= CHECK_XOR8;
    raw(8'h03, 0, 1'b1, `ERR_BAD_CHECKSUM);
    raw(8'h03, 0, 1'b0, `ERR_NONE);
    raw(8'h03, 1, 1'b0, `ERR_MANY_PARAMS);
    raw(8'h03, 257, 1'b0, `ERR_SERIAL_OVERFLOW);
    give_verdict();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    give_verdict();
  end
endmodule // host_cmd_integrity_errors_bench
